// *** pkg/ext_irq_pkg.sv ***
// constants, layouts and types of the external interrupt unit
package ext_irq_pkg;
  localparam int          NUM_LINES     = 31;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_MODE      = 8'h00;
  localparam logic [7:0]  OFS_EDGE      = 8'h04;
  localparam logic [7:0]  OFS_ASYNC     = 8'h08;
  localparam logic [7:0]  OFS_FILTER    = 8'h0C;
  localparam logic [7:0]  OFS_ENABLE    = 8'h30;
  localparam logic [7:0]  OFS_DISABLE   = 8'h34;
  localparam logic [7:0]  OFS_CTRL      = 8'h38;
  localparam logic [7:0]  OFS_MASK      = 8'h40;
  localparam logic [7:0]  OFS_STATUS    = 8'h44;
  localparam logic [31:0] RESET_ZERO    = 32'h0000_0000;
  localparam logic [31:0] USED_BITS     = 32'h7FFF_FFFF;
  localparam int          NMI_BIT       = 0;
  localparam int          FILTER_TAPS   = 3;

  typedef struct packed {
    logic [NUM_LINES-1:0] level_mode;
    logic [NUM_LINES-1:0] high_rise;
    logic [NUM_LINES-1:0] async_mode;
    logic [NUM_LINES-1:0] filter_on;
  } line_cfg_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
  } bus_req_t;
endpackage : ext_irq_pkg

// *** design/external_interrupt_unit.sv ***
// external interrupt unit: detection, wake and avalon register slave
`timescale 1ns/10ps
module external_interrupt_unit #(
  parameter int LINES = ext_irq_pkg::NUM_LINES
) (
  input  wire logic                               CLOCK_I,
  input  wire logic                               RST_B_I,
  input  wire logic [LINES-1:0]                   EXT_IRQ_PIN_I,
  input  wire logic                               SYNC_CLK_RUN_I,
  input  wire logic                               DEBUG_HALT_I,
  input  wire logic                               AVS_READ_I,
  input  wire logic                               AVS_WRITE_I,
  input  wire logic [ext_irq_pkg::ADDR_W-1:0]     AVS_ADDRESS_I,
  input  wire logic [31:0]                        AVS_WRITEDATA_I,
  output logic [31:0]                             AVS_READDATA_O,
  output logic                                    AVS_WAITREQUEST_O,
  output logic [LINES-1:1]                        IRQ_LINE_O,
  output logic                                    NMI_O,
  output logic                                    IRQ_O,
  output logic                                    WAKE_REQUEST_O,
  output logic                                    WAKE_TO_HANDLER_O,
  output logic                                    BUS_CLK_REQ_O
);
  ext_irq_pkg::line_cfg_t  cfg_reg;
  ext_irq_pkg::bus_req_t   req;
  logic [LINES-1:0]        enable_reg;
  logic [LINES-1:0]        mask_reg;
  logic [LINES-1:0]        status_reg;
  logic [LINES-1:0]        status_next;
  logic [LINES-1:0]        async_pend_reg;
  logic [LINES-1:0]        tap0_reg;
  logic [LINES-1:0]        tap1_reg;
  logic [LINES-1:0]        tap2_reg;
  logic [LINES-1:0]        filt_reg;
  logic [LINES-1:0]        filt_prev_reg;
  logic [LINES-1:0]        majority;
  logic [LINES-1:0]        filt_next;
  logic [LINES-1:0]        sync_event;
  logic [LINES-1:0]        async_hit;
  logic [LINES-1:0]        clear_bits;
  logic                    ack_reg;
  logic                    wr_take;
  logic                    bus_clk_reg;

  function automatic logic [LINES-1:0] field(input logic [31:0] d);
    field = d[LINES-1:0];
  endfunction : field

  function automatic logic [31:0] widen(input logic [LINES-1:0] d);
    widen = ext_irq_pkg::USED_BITS & {{(32-LINES){1'b0}}, d};
  endfunction : widen

  assign req.read      = AVS_READ_I;
  assign req.write     = AVS_WRITE_I;
  assign req.address   = AVS_ADDRESS_I;
  assign req.writedata = AVS_WRITEDATA_I;

  // one wait cycle per access; keeps read data registered
  assign AVS_WAITREQUEST_O = (req.read | req.write) & ~ack_reg;
  assign wr_take           = req.write & ack_reg;

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      ack_reg <= 1'b0;
    else
      ack_reg <= (req.read | req.write) & ~ack_reg;
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      AVS_READDATA_O <= ext_irq_pkg::RESET_ZERO;
    else if (req.read && !ack_reg)
    begin
      case (req.address)
        ext_irq_pkg::OFS_MODE:   AVS_READDATA_O <= widen(cfg_reg.level_mode);
        ext_irq_pkg::OFS_EDGE:   AVS_READDATA_O <= widen(cfg_reg.high_rise);
        ext_irq_pkg::OFS_ASYNC:  AVS_READDATA_O <= widen(cfg_reg.async_mode);
        ext_irq_pkg::OFS_FILTER: AVS_READDATA_O <= widen(cfg_reg.filter_on);
        ext_irq_pkg::OFS_CTRL:   AVS_READDATA_O <= widen(enable_reg);
        ext_irq_pkg::OFS_MASK:   AVS_READDATA_O <= widen(mask_reg);
        ext_irq_pkg::OFS_STATUS: AVS_READDATA_O <= widen(status_reg);
        default:                 AVS_READDATA_O <= ext_irq_pkg::RESET_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      cfg_reg <= '0;
    else if (wr_take)
    begin
      case (req.address)
        ext_irq_pkg::OFS_MODE:   cfg_reg.level_mode <= field(req.writedata);
        ext_irq_pkg::OFS_EDGE:   cfg_reg.high_rise  <= field(req.writedata);
        ext_irq_pkg::OFS_ASYNC:  cfg_reg.async_mode <= field(req.writedata);
        ext_irq_pkg::OFS_FILTER: cfg_reg.filter_on  <= field(req.writedata);
        default:                 cfg_reg <= cfg_reg;
      endcase
    end
  end

  // enable is set by one register, cleared by the write-only disable register
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      enable_reg <= '0;
    else if (wr_take && req.address == ext_irq_pkg::OFS_ENABLE)
      enable_reg <= enable_reg | field(req.writedata);
    else if (wr_take && req.address == ext_irq_pkg::OFS_DISABLE)
      enable_reg <= enable_reg & ~field(req.writedata);
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      mask_reg <= '0;
    else if (wr_take && req.address == ext_irq_pkg::OFS_MASK)
      mask_reg <= field(req.writedata);
  end

  // filter and sync detection only move while the sync clock runs
  always_comb
  begin
    majority  = (tap0_reg & tap1_reg) | (tap1_reg & tap2_reg) | (tap0_reg & tap2_reg);
    filt_next = (cfg_reg.filter_on & majority) | (~cfg_reg.filter_on & tap0_reg);
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      tap0_reg      <= '0;
      tap1_reg      <= '0;
      tap2_reg      <= '0;
      filt_reg      <= '0;
      filt_prev_reg <= '0;
    end
    else if (SYNC_CLK_RUN_I)
    begin
      tap0_reg      <= EXT_IRQ_PIN_I;
      tap1_reg      <= tap0_reg;
      tap2_reg      <= tap1_reg;
      filt_reg      <= filt_next;
      filt_prev_reg <= filt_reg;
    end
  end

  // level, rising or falling; debug halt is deliberately not a term here
  always_comb
  begin
    // detectors only report while the sync clock runs, frozen filter must not re-fire
    sync_event = {LINES{SYNC_CLK_RUN_I}} & enable_reg & ~cfg_reg.async_mode & (
        (cfg_reg.level_mode & ~(filt_reg ^ cfg_reg.high_rise))
      | (~cfg_reg.level_mode & cfg_reg.high_rise & filt_reg & ~filt_prev_reg)
      | (~cfg_reg.level_mode & ~cfg_reg.high_rise & ~filt_reg & filt_prev_reg));
  end

  // async path looks at the raw pin, no sync clock term: catches short spikes
  assign async_hit = enable_reg & cfg_reg.async_mode
                   & ~(EXT_IRQ_PIN_I ^ cfg_reg.high_rise);

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      async_pend_reg <= '0;
    else
      async_pend_reg <= (async_pend_reg | async_hit)
                      & ~({LINES{SYNC_CLK_RUN_I}} & async_pend_reg);
  end

  assign clear_bits = (wr_take && req.address == ext_irq_pkg::OFS_STATUS)
                    ? field(req.writedata) : '0;

  // set beats a clear in the same cycle
  always_comb
  begin
    status_next = (status_reg & ~clear_bits) | sync_event
                | ({LINES{SYNC_CLK_RUN_I}} & async_pend_reg);
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      bus_clk_reg <= 1'b0;
    else
      bus_clk_reg <= 1'b1;
  end

  assign BUS_CLK_REQ_O     = bus_clk_reg;
  assign IRQ_LINE_O        = status_reg[LINES-1:1] & mask_reg[LINES-1:1];
  assign NMI_O             = status_reg[ext_irq_pkg::NMI_BIT];
  assign IRQ_O             = |(status_reg & mask_reg);
  assign WAKE_REQUEST_O    = |(async_hit | async_pend_reg);
  assign WAKE_TO_HANDLER_O = |((async_hit | async_pend_reg) & mask_reg);

  ack_one_wait_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    (AVS_READ_I | AVS_WRITE_I) && !ack_reg |=> ack_reg)
    else $error("bus access not acknowledged after one wait cycle");
  enable_reset_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    $rose(RST_B_I) |-> enable_reg == '0)
    else $error("inputs enabled after reset");
  disable_clears_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    wr_take && AVS_ADDRESS_I == ext_irq_pkg::OFS_DISABLE |=>
      (enable_reg & field($past(AVS_WRITEDATA_I))) == '0)
    else $error("disable write left an input enabled");
  nmi_disable_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    wr_take && AVS_ADDRESS_I == ext_irq_pkg::OFS_DISABLE && !AVS_WRITEDATA_I[0]
      |=> enable_reg[0] == $past(enable_reg[0]))
    else $error("zero in disable bit changed nmi enable");
  sync_frozen_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    !SYNC_CLK_RUN_I |=> $stable(filt_reg) && $stable(tap0_reg))
    else $error("filter moved with sync clock halted");
  async_wake_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    |async_hit |-> WAKE_REQUEST_O ##1 (WAKE_REQUEST_O || SYNC_CLK_RUN_I))
    else $error("async spike gave no held wake");
  wake_status_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    (async_pend_reg != '0) && SYNC_CLK_RUN_I |=>
      (status_reg & $past(async_pend_reg)) == $past(async_pend_reg))
    else $error("status missed event on sync clock restart");
  line_mask_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    IRQ_LINE_O == (status_reg[LINES-1:1] & mask_reg[LINES-1:1]) && (IRQ_O == |(status_reg & mask_reg)))
    else $error("request lines disagree with status and mask");
  nmi_unmasked_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    status_reg[0] && !mask_reg[0] |-> NMI_O)
    else $error("nmi gated by mask");
  debug_run_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    DEBUG_HALT_I && |sync_event |=> (status_reg & $past(sync_event)) == $past(sync_event))
    else $error("detection stopped under debug halt");
  handler_wake_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    WAKE_TO_HANDLER_O |-> WAKE_REQUEST_O && |(mask_reg & (async_hit | async_pend_reg)))
    else $error("handler wake without masked source");
  bus_clk_on_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    $rose(RST_B_I) |-> ##[1:2] BUS_CLK_REQ_O)
    else $error("bus clock request not raised");
  halted_quiet_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    !SYNC_CLK_RUN_I |-> sync_event == '0)
    else $error("sync detector active with sync clock halted");
  set_wins_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    (clear_bits & sync_event) != '0 |=> (status_reg & $past(sync_event)) == $past(sync_event))
    else $error("status clear beat a new event");
  enable_set_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    wr_take && AVS_ADDRESS_I == ext_irq_pkg::OFS_ENABLE |=>
      (enable_reg & field($past(AVS_WRITEDATA_I))) == field($past(AVS_WRITEDATA_I)))
    else $error("enable write left an input disabled");
endmodule : external_interrupt_unit

// *** verif/sys_irq_ctrl_model.sv ***
// model of the system interrupt controller behind the unit
`timescale 1ns/10ps
module sys_irq_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        enable_i,
  input  wire logic [30:1] irq_line_i,
  input  wire logic        nmi_i,
  output logic [30:1]      seen_o,
  output logic             nmi_seen_o
);
  // lines are only taken once software has programmed the controller
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      seen_o <= '0;
    else if (enable_i)
      seen_o <= seen_o | irq_line_i;
  // the non-maskable path ignores the controller enable
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      nmi_seen_o <= 1'b0;
    else
      nmi_seen_o <= nmi_seen_o | nmi_i;
endmodule : sys_irq_ctrl_model

// *** verif/external_interrupt_unit_bench.sv ***
// self-checking bench of the external interrupt unit
`timescale 1ns/10ps
module external_interrupt_unit_bench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [30:0] pins = '0;
  logic        sync_run = 1'b1;
  logic        dbg = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic        ctrl_en = 1'b0;
  logic [31:0] rdata;
  logic        waitreq;
  logic [30:1] irq_line;
  logic [30:1] seen;
  logic        nmi, irq, wake, wake_h, bus_req, nmi_seen;
  int          err_count = 0;
  int          n_compared = 0;

  external_interrupt_unit external_interrupt_unit_inst (.CLOCK_I(clk), .RST_B_I(rst_b),
    .EXT_IRQ_PIN_I(pins), .SYNC_CLK_RUN_I(sync_run), .DEBUG_HALT_I(dbg), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_ADDRESS_I(addr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .IRQ_LINE_O(irq_line), .NMI_O(nmi), .IRQ_O(irq),
    .WAKE_REQUEST_O(wake), .WAKE_TO_HANDLER_O(wake_h), .BUS_CLK_REQ_O(bus_req));
  sys_irq_ctrl_model sys_irq_ctrl_model_inst (.clk_i(clk), .rst_b_i(rst_b), .enable_i(ctrl_en),
    .irq_line_i(irq_line), .nmi_i(nmi), .seen_o(seen), .nmi_seen_o(nmi_seen));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    if (n >= 50)
      chk("bus answer", 0, 1);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(name, exp, q);
  endtask : rd_chk

  task automatic t_reset();
    rd_chk("enabled after reset", ext_irq_pkg::OFS_CTRL, 32'h0);
    chk("bus clock request", 1, bus_req);
    rd_chk("unmapped read", 8'h20, 32'h0);
    wr_reg(ext_irq_pkg::OFS_EDGE, 32'h0000_0004);
    pins[2] <= 1'b1;
    rd_chk("status of disabled line", ext_irq_pkg::OFS_STATUS, 32'h0);
    chk("irq of disabled line", 0, irq);
    pins[2] <= 1'b0;
    $display("test reset done");
  endtask : t_reset

  task automatic t_sync();
    int i;
    dbg <= 1'b1;
    ctrl_en <= 1'b1;
    wr_reg(ext_irq_pkg::OFS_EDGE, 32'h0000_0020);
    wr_reg(ext_irq_pkg::OFS_ENABLE, 32'h0000_0020);
    wr_reg(ext_irq_pkg::OFS_MASK, 32'h0000_0020);
    pins[5] <= 1'b1;
    for (i = 0; i < 20 && irq_line[5] !== 1'b1; i++)
      @(posedge clk);
    @(negedge clk);
    chk("line 5 request in debug halt", 1, irq_line[5]);
    chk("controller saw line 5", 1, seen[5]);
    rd_chk("status line 5", ext_irq_pkg::OFS_STATUS, 32'h0000_0020);
    pins[5] <= 1'b0;
    wr_reg(ext_irq_pkg::OFS_STATUS, 32'h0000_0020);
    rd_chk("status cleared", ext_irq_pkg::OFS_STATUS, 32'h0);
    chk("irq after clear", 0, irq);
    dbg <= 1'b0;
    $display("test sync done");
  endtask : t_sync

  task automatic t_disable();
    int i;
    wr_reg(ext_irq_pkg::OFS_ENABLE, 32'h7FFF_FFFF);
    wr_reg(ext_irq_pkg::OFS_DISABLE, 32'h8000_0000);
    rd_chk("reserved bit 31", ext_irq_pkg::OFS_CTRL, 32'h7FFF_FFFF);
    wr_reg(ext_irq_pkg::OFS_DISABLE, 32'h5555_5554);
    rd_chk("partial disable", ext_irq_pkg::OFS_CTRL, 32'h2AAA_AAAB);
    wr_reg(ext_irq_pkg::OFS_MASK, 32'h0);
    wr_reg(ext_irq_pkg::OFS_EDGE, 32'h0000_0001);
    ctrl_en <= 1'b0;
    pins[0] <= 1'b1;
    for (i = 0; i < 20 && nmi !== 1'b1; i++)
      @(posedge clk);
    @(negedge clk);
    chk("unmasked nmi", 1, nmi);
    chk("nmi without controller", 1, nmi_seen);
    pins[0] <= 1'b0;
    wr_reg(ext_irq_pkg::OFS_STATUS, 32'h0000_0001);
    wr_reg(ext_irq_pkg::OFS_DISABLE, 32'h0000_0001);
    rd_chk("nmi disable", ext_irq_pkg::OFS_CTRL, 32'h2AAA_AAAA);
    wr_reg(ext_irq_pkg::OFS_DISABLE, 32'h7FFF_FFFF);
    rd_chk("all disabled", ext_irq_pkg::OFS_CTRL, 32'h0);
    $display("test disable done");
  endtask : t_disable

  // line 3 async wakes the halted unit, line 6 sync must not
  task automatic t_wake(input logic m);
    wr_reg(ext_irq_pkg::OFS_EDGE, 32'h0000_0048);
    wr_reg(ext_irq_pkg::OFS_ASYNC, 32'h0000_0008);
    wr_reg(ext_irq_pkg::OFS_MASK, {28'h0, m, 3'h0});
    wr_reg(ext_irq_pkg::OFS_ENABLE, 32'h0000_0048);
    @(posedge clk);
    sync_run <= 1'b0;
    @(posedge clk);
    pins[3] <= 1'b1;
    pins[6] <= 1'b1;
    @(negedge clk);
    chk("wake on spike", 1, wake);
    @(posedge clk);
    pins[3] <= 1'b0;
    pins[6] <= 1'b0;
    @(negedge clk);
    chk("wake to handler", {31'h0, m}, wake_h);
    rd_chk("status while halted", ext_irq_pkg::OFS_STATUS, 32'h0);
    sync_run <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("request after restart", {31'h0, m}, irq_line[3]);
    rd_chk("status after restart", ext_irq_pkg::OFS_STATUS, 32'h0000_0008);
    wr_reg(ext_irq_pkg::OFS_STATUS, 32'h0000_0008);
    wr_reg(ext_irq_pkg::OFS_DISABLE, 32'h0000_0048);
    $display("test wake done");
  endtask : t_wake

  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_sync();
    t_disable();
    t_wake(1'b0);
    t_wake(1'b1);
    end_sim();
  end

  // the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule : external_interrupt_unit_bench
